// >>> hdl/tcam_pkg.sv
// Package with constants and types shared by the ternary search engine design.
package tcam_pkg;

   // *******************************************************
   // Widths and array geometry
   // *******************************************************
   localparam int DQ_W = 68;
   localparam int WORD_W = 136;
   localparam int OP_W = 9;
   localparam int ADDR_W = 6;
   localparam int DEPTH = 64;
   localparam int SECTIONS = 4;
   localparam int CASC_IN_W = 7;
   localparam int ID_W = 4;
   localparam int SRAM_ADDR_W = 22;
   localparam int SRAM_HI_W = SRAM_ADDR_W - ADDR_W;
   localparam int VALID_BIT = 0;
   localparam int CFG_GATE_OFF_BIT = 0;

   // *******************************************************
   // Instruction field layout and device identity
   // *******************************************************
   localparam int OPC_LSB = 0;
   localparam int OPC_MSB = 1;
   localparam int PARAM_LSB = 2;
   localparam int PARAM_MSB = 8;
   localparam logic [ID_W-1:0] ID_MAX = 4'h7;
   localparam logic [ID_W-1:0] ID_BROADCAST = 4'hf;
   localparam logic [1:0] TABLE_SIZE_FIELD_SINGLE = 2'h0;

   // *******************************************************
   // Reset values and timing
   // *******************************************************
   localparam logic [WORD_W-1:0] GMASK_RST = '0;
   localparam int SEARCH_TO_CASCADE = 4;
   localparam int LAT_SINGLE = 4;
   localparam int LAT_CASCADE = 5;
   localparam int CLK_PERIOD_NS = 50;

   typedef enum logic [1:0] {
      OPC_READ = 2'b00,
      OPC_WRITE = 2'b01,
      OPC_SEARCH = 2'b10,
      OPC_WRITE_NFA = 2'b11
   } opcode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HALF_A = 2'b01,
      ST_HALF_B = 2'b10
   } ingress_state_t;

endpackage

// >>> hdl/tcam_cmd_if.sv
// Interface carrying an assembled instruction and word from ingress to the core.
`timescale 1ns/1ns
interface tcam_cmd_if;
   import tcam_pkg::*;
   logic valid;
   opcode_t opcode;
   logic [PARAM_MSB-PARAM_LSB:0] param;
   logic [WORD_W-1:0] word;
   modport src (output valid, opcode, param, word);
   modport dst (input valid, opcode, param, word);
endinterface

// >>> hdl/tcam_ingress.sv
// Ingress that joins two bus halves, taken on consecutive rising edges, into one word.
`timescale 1ns/1ns
module tcam_ingress
   import tcam_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic phase,
   input wire logic op_valid,
   input wire logic [OP_W-1:0] instr,
   input wire logic [DQ_W-1:0] dq,
   tcam_cmd_if.src cmd
);
   logic [DQ_W-1:0] high_r;
   logic [OP_W-1:0] op_r;
   logic pend_r;
   logic first_half;
   logic second_half;

   assign first_half = op_valid && !phase;
   assign second_half = pend_r && phase;

   // *******************************************************
   // First half holds bits 135:68, second half bits 67:0
   // *******************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         high_r <= '0;
         op_r <= '0;
         pend_r <= 1'b0;
         cmd.valid <= 1'b0;
         cmd.opcode <= OPC_READ;
         cmd.param <= '0;
         cmd.word <= '0;
      end else begin
         cmd.valid <= second_half; // [R12]
         pend_r <= first_half;
         if (first_half) begin
            high_r <= dq; // [R12]
            op_r <= instr;
         end
         if (second_half) begin
            cmd.word <= {high_r, dq}; // [R12]
            cmd.opcode <= opcode_t'(op_r[OPC_MSB:OPC_LSB]); // [R23]
            cmd.param <= op_r[PARAM_MSB:PARAM_LSB]; // [R23]
         end
      end
   end
endmodule

// >>> hdl/tcam_match_row.sv
// One ternary array word: storage and masked compare.
`timescale 1ns/1ns
module tcam_match_row
   import tcam_pkg::*;
(
   input wire logic sys_clk,
   input wire logic wr_en,
   input wire logic [WORD_W-1:0] wr_data,
   input wire logic [WORD_W-1:0] wr_care,
   input wire logic [WORD_W-1:0] key,
   input wire logic [WORD_W-1:0] gmask,
   output logic hit,
   output logic valid
);
   // Array contents have no reset: reset must not clear them.
   logic [WORD_W-1:0] data_r;
   logic [WORD_W-1:0] care_r;
   logic [WORD_W-1:0] miss;

   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         data_r <= wr_data; // [R18]
         care_r <= wr_care;
      end
   end

   // A cleared care bit is a don't-care; a cleared global mask bit also ignores.
   assign miss = (data_r ^ key) & care_r & gmask; // [R9]
   assign hit = ~|miss;
   assign valid = data_r[VALID_BIT]; // [R10]
endmodule

// >>> hdl/tcam_engine.sv
// Control core of the ternary search engine with cascade and SRAM arbitration.
// Summary of operation
// R1 - Unused cascade inputs tied low by system.
// R2 - Both cascade outputs carry one value.
// R3 - Unused full inputs tied high by system.
// R4 - Full outputs high when every entry valid.
// R5 - Table-full flag shows whole cascade full.
// R6 - Block-hit inputs grounded for small cascades.
// R7 - Strap gives identity; fifteen means broadcast.
// R8 - Broadcast read answered only by last-in-table.
// R9 - Elements hold data and mask, ternary; core writes every mask as all ones.
// R10 - Bit zero is valid; finds free address.
// R11 - Lowest matching address wins under mask.
// R12 - Bus halves sampled on rising edges.
// R13 - Matching device drives SRAM, else last.
// R14 - SRAM outputs delayed in cascade; no data.
// R15 - SRAM address from bus plus match address.
// R16 - Broadcast SRAM access driven by last device.
// R17 - Low enables gate sections; config disables.
// R18 - Reset sets state, keeps array contents.
// R19 - Host clears valid bits and programs widths.
// R20 - Only last device gets last bits set.
// R21 - Single device: table size zero, shorter latency.
// R22 - Global masks reset to zero.
// R23 - Opcode bits select read/write/search/write-free.
// R24 - Cascade result driven four cycles after search.
// R25 - Table full needs self full and inputs high.
// R26 - Cascade and full outputs active high.
`timescale 1ns/1ns
module tcam_engine
   import tcam_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic phase,
   input wire logic op_valid,
   input wire logic [OP_W-1:0] instruction_bus,
   input wire logic [DQ_W-1:0] dq_in,
   input wire logic [CASC_IN_W-1:0] cascade_in,
   input wire logic [CASC_IN_W-1:0] full_in,
   input wire logic [2:0] block_hit_in,
   input wire logic [ID_W-1:0] device_id_strap,
   input wire logic [SECTIONS-1:0] section_search_enable_n,
   input wire logic last_in_table_bit,
   input wire logic last_on_sram_bus_bit,
   input wire logic [1:0] table_size_field,
   input wire logic gate_disable_cfg,
   input wire logic [WORD_W-1:0] gmask_load,
   input wire logic gmask_load_en,
   output logic [1:0] cascade_out,
   output logic [1:0] full_out,
   output logic [2:0] block_hit_out,
   output logic table_full_flag,
   output logic [DQ_W-1:0] dq_out,
   output logic dq_oe,
   output logic read_ack,
   output logic match_flag,
   output logic match_valid,
   output logic [ADDR_W-1:0] next_free_addr,
   output logic [SRAM_ADDR_W-1:0] sram_addr,
   output logic sram_ce_n,
   output logic sram_we_n,
   output logic sram_oe_n,
   output logic sram_ale_n,
   output logic sram_clk
);
   localparam int DLY_MAX = LAT_CASCADE + 1;

   // *******************************************************
   // Reset release and pin synchronisers
   // *******************************************************
   logic [1:0] rst_sync_r;
   logic rst_n;
   logic [CASC_IN_W-1:0] casc_s1_r, casc_s2_r, full_s1_r, full_s2_r;
   logic [ID_W-1:0] id_s1_r, id_s2_r;
   logic [SECTIONS-1:0] sen_s1_r, sen_s2_r;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         casc_s1_r <= '0;
         casc_s2_r <= '0;
         full_s1_r <= '1;
         full_s2_r <= '1;
         id_s1_r <= '0;
         id_s2_r <= '0;
         sen_s1_r <= '0;
         sen_s2_r <= '0;
      end else begin
         casc_s1_r <= cascade_in;
         casc_s2_r <= casc_s1_r;
         full_s1_r <= full_in;
         full_s2_r <= full_s1_r;
         id_s1_r <= device_id_strap;
         id_s2_r <= id_s1_r;
         sen_s1_r <= section_search_enable_n;
         sen_s2_r <= sen_s1_r;
      end
   end

   // *******************************************************
   // Instruction ingress and addressing
   // *******************************************************
   tcam_cmd_if cmd ();

   tcam_ingress u_ingress (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .phase(phase),
      .op_valid(op_valid),
      .instr(instruction_bus),
      .dq(dq_in),
      .cmd(cmd)
   );

   logic [ID_W-1:0] op_id;
   logic broadcast, id_ok, addressed;
   logic [ADDR_W-1:0] op_addr;
   logic is_read, is_write, is_search, is_wnfa;

   assign op_id = cmd.param[ID_W-1:0];
   assign broadcast = op_id == ID_BROADCAST; // [R7]
   assign id_ok = id_s2_r <= ID_MAX;
   assign addressed = id_ok && (broadcast || op_id == id_s2_r); // [R7]
   assign op_addr = cmd.word[DQ_W+ADDR_W-1:DQ_W];
   assign is_read = cmd.valid && cmd.opcode == OPC_READ && addressed; // [R23]
   assign is_write = cmd.valid && cmd.opcode == OPC_WRITE && addressed;
   assign is_search = cmd.valid && cmd.opcode == OPC_SEARCH; // [R23]
   assign is_wnfa = cmd.valid && cmd.opcode == OPC_WRITE_NFA && addressed;

   // *******************************************************
   // Global mask, array and priority encode
   // *******************************************************
   logic [WORD_W-1:0] gmask_r;
   logic [DEPTH-1:0] hits, valids, row_wr, sect_on;
   logic gating_off;
   logic all_full;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gmask_r <= GMASK_RST; // [R22]
      end else if (gmask_load_en) begin
         gmask_r <= gmask_load;
      end
   end

   // Gating is off by config bit or with every enable held low.
   assign gating_off = gate_disable_cfg || sen_s2_r == '0; // [R17]

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_row
         assign sect_on[g] = gating_off || !sen_s2_r[g / (DEPTH / SECTIONS)]; // [R17]
         assign row_wr[g] = (is_write && op_addr == ADDR_W'(g)) ||
                            (is_wnfa && next_free_addr == ADDR_W'(g) && !all_full);
         tcam_match_row u_row (
            .sys_clk(sys_clk),
            .wr_en(row_wr[g]),
            .wr_data(cmd.word),
            .wr_care('1),
            .key(cmd.word),
            .gmask(gmask_r),
            .hit(hits[g]),
            .valid(valids[g])
         );
      end
   endgenerate

   logic [DEPTH-1:0] live_hits;
   logic any_hit;
   logic [ADDR_W-1:0] hit_addr, free_addr;

   assign live_hits = hits & valids & sect_on;
   assign any_hit = |live_hits;
   assign all_full = &valids; // [R4]

   // Lowest index first; loops run downward so the lowest assignment lands last.
   always_comb begin
      hit_addr = '0;
      free_addr = '0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (live_hits[i]) begin
            hit_addr = ADDR_W'(i); // [R11]
         end
         if (!valids[i]) begin
            free_addr = ADDR_W'(i); // [R10]
         end
      end
   end

   // *******************************************************
   // Search pipeline and cascade arbitration
   // *******************************************************
   logic [DLY_MAX-1:0] srch_pipe_r;
   logic [DLY_MAX-1:0] hit_pipe_r;
   logic [ADDR_W-1:0] haddr_pipe_r [DLY_MAX];
   logic [SRAM_HI_W-1:0] hi_pipe_r [DLY_MAX];
   logic cascaded;
   logic [2:0] res_tap;
   logic res_srch, res_hit, upstream_hit, own_bus;

   // Table size zero means a lone device and the short latency.
   assign cascaded = table_size_field != TABLE_SIZE_FIELD_SINGLE; // [R21]
   assign res_tap = cascaded ? 3'(LAT_CASCADE - 1) : 3'(LAT_SINGLE - 1); // [R14]
   assign res_srch = srch_pipe_r[res_tap];
   assign res_hit = hit_pipe_r[res_tap];
   // Unused cascade inputs are low, so they never claim the bus.
   assign upstream_hit = |casc_s2_r; // [R1]
   assign own_bus = res_hit ? !(cascaded && upstream_hit) :
                    (last_on_sram_bus_bit && (!cascaded || !upstream_hit)); // [R13]

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         srch_pipe_r <= '0;
         hit_pipe_r <= '0;
         for (int i = 0; i < DLY_MAX; i++) begin
            haddr_pipe_r[i] <= '0;
            hi_pipe_r[i] <= '0;
         end
      end else begin
         srch_pipe_r <= {srch_pipe_r[DLY_MAX-2:0], is_search};
         hit_pipe_r <= {hit_pipe_r[DLY_MAX-2:0], is_search && any_hit};
         haddr_pipe_r[0] <= hit_addr;
         hi_pipe_r[0] <= cmd.word[SRAM_HI_W-1:0]; // [R15]
         for (int i = 1; i < DLY_MAX; i++) begin
            haddr_pipe_r[i] <= haddr_pipe_r[i-1];
            hi_pipe_r[i] <= hi_pipe_r[i-1];
         end
      end
   end

   // *******************************************************
   // Outputs
   // *******************************************************
   logic [SRAM_ADDR_W-1:0] sram_addr_nxt;
   logic sram_drive_nxt, sram_wr_nxt, explicit_own, rd_answer;

   // Broadcast explicit access belongs to the last device only.
   assign explicit_own = broadcast ? last_on_sram_bus_bit : addressed; // [R16]
   assign rd_answer = is_read && (!broadcast || last_in_table_bit); // [R8]
   assign sram_drive_nxt = (res_srch && own_bus) ||
                           (cmd.valid && cmd.param[PARAM_MSB] && explicit_own &&
                            (cmd.opcode == OPC_READ || cmd.opcode == OPC_WRITE));
   assign sram_wr_nxt = cmd.valid && cmd.param[PARAM_MSB] && cmd.opcode == OPC_WRITE;
   assign sram_addr_nxt = res_srch ? {hi_pipe_r[res_tap], haddr_pipe_r[res_tap]} :
                          {cmd.word[SRAM_HI_W-1:0], op_addr}; // [R15]

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cascade_out <= 2'h0;
         full_out <= 2'h0;
         block_hit_out <= 3'h0;
         table_full_flag <= 1'b0;
         dq_out <= '0;
         dq_oe <= 1'b0;
         read_ack <= 1'b0;
         match_flag <= 1'b0;
         match_valid <= 1'b0;
         next_free_addr <= '0;
         sram_addr <= '0;
         sram_ce_n <= 1'b1;
         sram_we_n <= 1'b1;
         sram_oe_n <= 1'b1;
         sram_ale_n <= 1'b1;
         sram_clk <= 1'b0;
      end else begin
         cascade_out <= {2{hit_pipe_r[SEARCH_TO_CASCADE-1]}}; // [R24] [R2] [R26]
         full_out <= {2{all_full}}; // [R4] [R26]
         table_full_flag <= all_full && (&full_s2_r); // [R5] [R25] [R3]
         next_free_addr <= free_addr; // [R10]
         dq_out <= rd_answer ? cmd.word[DQ_W-1:0] : '0;
         dq_oe <= rd_answer; // [R8]
         read_ack <= rd_answer;
         match_valid <= res_srch && (res_hit || last_in_table_bit);
         match_flag <= res_srch && res_hit && own_bus;
         sram_addr <= sram_drive_nxt ? sram_addr_nxt : sram_addr; // [R14]
         sram_ce_n <= !sram_drive_nxt; // [R13]
         sram_ale_n <= !sram_drive_nxt;
         sram_we_n <= !(sram_drive_nxt && sram_wr_nxt);
         sram_oe_n <= !(sram_drive_nxt && !sram_wr_nxt);
         sram_clk <= !sram_clk;
      end
   end
endmodule

// >>> testbench/tcam_engine_sva.sv
// Concurrent assertions on the ports of the search engine core.
`timescale 1ns/1ns
module tcam_engine_sva
   import tcam_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic phase,
   input wire logic op_valid,
   input wire logic [OP_W-1:0] instruction_bus,
   input wire logic [CASC_IN_W-1:0] full_in,
   input wire logic [ID_W-1:0] device_id_strap,
   input wire logic last_in_table_bit,
   input wire logic [1:0] cascade_out,
   input wire logic [1:0] full_out,
   input wire logic [2:0] block_hit_out,
   input wire logic table_full_flag,
   input wire logic dq_oe,
   input wire logic read_ack
);
   logic [7:0] srch_r;
   wire take = op_valid && !phase && !instruction_bus[8];
   wire [1:0] opc = instruction_bus[1:0];
   wire [3:0] tid = instruction_bus[5:2];
   wire rd_take = take && opc == 2'h0;
   // Remembers searches taken over the last eight edges.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         srch_r <= '0;
      end else begin
         srch_r <= {srch_r[6:0], take && opc == 2'h2};
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_cascade_pair_same: assert property (cascade_out[1] == cascade_out[0])
      else $error("cascade outputs differ");
   a_full_pair_same: assert property (full_out[1] == full_out[0])
      else $error("full outputs differ");
   a_table_full_self: assert property (table_full_flag |-> full_out == 2'h3)
      else $error("table full without local full");
   a_table_full_inputs: assert property ((!(&full_in))[*5] |-> !table_full_flag)
      else $error("table full while an upstream is not full");
   a_block_hit_idle: assert property (block_hit_out == 3'h0)
      else $error("block hit output active");
   a_cascade_after_search: assert property ($rose(cascade_out[0]) |-> |srch_r)
      else $error("cascade result without a search");
   a_own_read_answer: assert property (rd_take && tid == device_id_strap |-> ##3 read_ack)
      else $error("own read not answered on time");
   a_bcast_read_quiet: assert property (rd_take && tid == 4'hf && !last_in_table_bit
      |-> ##1 !read_ack [*4])
      else $error("broadcast read answered by non-last device");
   a_foreign_read_quiet: assert property (rd_take && tid != 4'hf && tid != device_id_strap
      |=> !read_ack [*4])
      else $error("read for another device answered");
   a_oe_with_ack: assert property (dq_oe |-> read_ack)
      else $error("data driven without acknowledge");
   c_search_hit: cover property (take && opc == 2'h2 ##[4:8] cascade_out[0]);
   c_table_full: cover property ($rose(table_full_flag));
   c_read_ack: cover property (read_ack);
endmodule
bind tcam_engine tcam_engine_sva chk (.sys_clk(sys_clk), .nrst(nrst), .phase(phase),
   .op_valid(op_valid), .instruction_bus(instruction_bus), .full_in(full_in),
   .device_id_strap(device_id_strap), .last_in_table_bit(last_in_table_bit),
   .cascade_out(cascade_out), .full_out(full_out), .block_hit_out(block_hit_out),
   .table_full_flag(table_full_flag), .dq_oe(dq_oe), .read_ack(read_ack));

// >>> testbench/upstream_peers.sv
// Model of the upstream cascaded peers feeding the cascade and full inputs.
`timescale 1ns/1ns
module upstream_peers
   import tcam_pkg::*;
(
   input wire logic [2:0] n_peers,
   input wire logic [CASC_IN_W-1:0] peer_hit,
   input wire logic [CASC_IN_W-1:0] peer_full,
   output logic [CASC_IN_W-1:0] cascade_in,
   output logic [CASC_IN_W-1:0] full_in,
   output logic [2:0] block_hit_in
);
   wire [CASC_IN_W-1:0] used = (7'h1 << n_peers) - 7'h1;
   assign cascade_in = peer_hit & used;
   assign full_in = peer_full | ~used;
   assign block_hit_in = 3'h0;
endmodule

// >>> testbench/test_ternary_cam_cascade_engine.sv
// Self-checking bench for the ternary search engine core.
`timescale 1ns/1ns
module test_ternary_cam_cascade_engine;
   import tcam_pkg::*;
   logic sys_clk, nrst, phase, op_valid, gate_disable_cfg, last_in_table_bit;
   logic [OP_W-1:0] instruction_bus;
   logic [DQ_W-1:0] dq_in;
   logic [ID_W-1:0] device_id_strap;
   logic [SECTIONS-1:0] section_search_enable_n;
   logic [2:0] n_peers, block_hit_in;
   logic [CASC_IN_W-1:0] peer_hit, peer_full, cascade_in, full_in;
   logic [1:0] cascade_out, full_out;
   logic table_full_flag, dq_oe, read_ack, match_flag;
   logic [ADDR_W-1:0] next_free_addr;
   logic [DQ_W-1:0] dq_out;
   logic [4:0] gates[5] = '{5'h1e, 5'h08, 5'h1f, 5'h16, 5'h00};
   int num_errors, samples_checked;
   int vld[DEPTH];
   upstream_peers peers (.n_peers(n_peers), .peer_hit(peer_hit), .peer_full(peer_full),
      .cascade_in(cascade_in), .full_in(full_in), .block_hit_in(block_hit_in));
   tcam_engine dut (.sys_clk(sys_clk), .nrst(nrst), .phase(phase), .op_valid(op_valid),
      .instruction_bus(instruction_bus), .dq_in(dq_in), .cascade_in(cascade_in),
      .full_in(full_in), .block_hit_in(block_hit_in), .device_id_strap(device_id_strap),
      .section_search_enable_n(section_search_enable_n),
      .last_in_table_bit(last_in_table_bit), .gate_disable_cfg(gate_disable_cfg),
      .last_on_sram_bus_bit(1'b1), .table_size_field(TABLE_SIZE_FIELD_SINGLE),
      .gmask_load('0), .gmask_load_en(1'b0), .cascade_out(cascade_out),
      .full_out(full_out), .block_hit_out(), .table_full_flag(table_full_flag),
      .dq_out(dq_out), .dq_oe(dq_oe), .read_ack(read_ack), .match_flag(match_flag),
      .match_valid(), .next_free_addr(next_free_addr), .sram_addr(), .sram_ce_n(),
      .sram_we_n(), .sram_oe_n(),
      .sram_ale_n(), .sram_clk());
   initial begin
      sys_clk = 1'b0;
      forever #(CLK_PERIOD_NS/2) sys_clk = ~sys_clk;
   end
   // *****************************
   // Shared tasks and the model
   // *****************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Sends one instruction as two bus halves on consecutive edges.
   task automatic issue(input logic [1:0] opc, input logic [3:0] id,
      input logic [67:0] hi, input logic [67:0] lo);
      @(posedge sys_clk);
      op_valid <= 1'b1;
      phase <= 1'b0;
      instruction_bus <= {3'h0, id, opc};
      dq_in <= hi;
      @(posedge sys_clk);
      op_valid <= 1'b0;
      phase <= 1'b1;
      dq_in <= lo;
   endtask
   task automatic wr(input int row, input logic [3:0] id, input logic v);
      issue(OPC_WRITE, id, {$urandom, 30'h0, 6'(row)}, {$urandom, $urandom, 3'h0, v});
      if (id == device_id_strap || id == ID_BROADCAST) vld[row] = int'(v);
   endtask
   function automatic int hit_exp();
      for (int r = 0; r < DEPTH; r++) begin
         if (vld[r] != 0 && (gate_disable_cfg || section_search_enable_n == '0 ||
               !section_search_enable_n[r/(DEPTH/SECTIONS)])) return 1;
      end
      return 0;
   endfunction
   // Global masks are still zero, so any key matches any valid word.
   task automatic search(input int exp);
      int seen;
      int mseen;
      seen = 0;
      mseen = 0;
      issue(OPC_SEARCH, ID_BROADCAST, {$urandom, $urandom, 4'h0}, {$urandom, $urandom, 4'h0});
      repeat (12) begin
         @(posedge sys_clk);
         #1 if (cascade_out[0] === 1'b1) seen = 1;
         if (match_flag === 1'b1) mseen = 1;
      end
      check(8'(seen), 8'(exp));
      check(8'(mseen), 8'(exp));
   endtask
   task automatic rd(input logic [3:0] id, input int exp);
      int acks;
      logic [31:0] lo;
      acks = 0;
      lo = $urandom;
      issue(OPC_READ, id, {62'h0, 6'h5}, {36'h0, lo});
      repeat (6) begin
         @(posedge sys_clk);
         #1 if (read_ack === 1'b1) begin
            acks++;
            check(dq_out[7:0], lo[7:0]);
         end
      end
      check(8'(acks), 8'(exp));
   endtask
   task automatic settle();
      logic f;
      f = 1'b1;
      foreach (vld[r]) if (vld[r] == 0) f = 1'b0;
      repeat (20) begin
         @(posedge sys_clk);
         #1 if (full_out === {2{f}} && table_full_flag === (f && &full_in)) break;
      end
      check({5'h0, full_out, table_full_flag}, {5'h0, f, f, f && &full_in});
   endtask
   // *****************************
   // Main sequence and watchdog
   // *****************************
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'h80c0544f));
      nrst = 1'b0;
      phase = 1'b0;
      op_valid = 1'b0;
      instruction_bus = '0;
      dq_in = '0;
      device_id_strap = 4'($urandom % 8);
      section_search_enable_n = '0;
      gate_disable_cfg = 1'b0;
      last_in_table_bit = 1'b1;
      n_peers = 3'h3;
      peer_hit = '0;
      peer_full = '1;
      repeat (16) @(posedge sys_clk);
      #1 check({3'h0, cascade_out, full_out, table_full_flag}, 8'h0);
      @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      for (int r = 0; r < DEPTH; r++) wr(r, device_id_strap, 1'b0);
      search(hit_exp());
      wr(40, device_id_strap, 1'b1);
      foreach (gates[i]) begin
         section_search_enable_n <= gates[i][4:1];
         gate_disable_cfg <= gates[i][0];
         repeat (4) @(posedge sys_clk);
         search(hit_exp());
      end
      for (int r = 0; r < DEPTH - 1; r++) wr(r, device_id_strap, 1'b1);
      wr(DEPTH - 1, device_id_strap ^ 4'h1, 1'b1);
      settle();
      wr(DEPTH - 1, ID_BROADCAST, 1'b1);
      settle();
      peer_full <= 7'h7b;
      settle();
      last_in_table_bit <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rd(ID_BROADCAST, 0);
      rd(device_id_strap ^ 4'h1, 0);
      rd(device_id_strap, 1);
      last_in_table_bit <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd(ID_BROADCAST, 1);
      wr(5, device_id_strap, 1'b0);
      settle();
      check(8'(next_free_addr), 8'h05);
      issue(OPC_WRITE_NFA, device_id_strap, {$urandom, 36'h0}, {$urandom, $urandom, 4'h1});
      vld[5] = 1;
      settle();
      print_verdict();
   end
endmodule
